/* File: acd_pkg.sv */
// acd_pkg: register map, field layout, reset values and carrier structs
// for the audio clock divider configuration slice.
// assumes a byte-wide register port and a single 125 MHz clock.
package acd_pkg;

   // register offsets on the control port
   localparam logic [7:0] OFS_DIV_ADDR   = 8'h1f;
   localparam logic [7:0] BCK_DIV_ADDR   = 8'h20;
   localparam logic [7:0] FRM_DIV_ADDR   = 8'h21;
   localparam logic [7:0] INTERP_ADDR    = 8'h22;
   localparam logic [7:0] STICKY_ADDR    = 8'h23;
   localparam logic [7:0] CLKDET_ADDR    = 8'h25;

   // field widths
   localparam int OFS_W  = 7;
   localparam int BCK_W  = 7;
   localparam int FRM_W  = 8;
   localparam int RATE_W = 3;
   localparam int EVT_W  = 8;

   // field positions
   localparam int INTERP_BIT      = 4;
   localparam int RATE_LSB        = 0;
   localparam int STICKY_BIT      = 0;
   localparam int IGN_RATE_BIT    = 6;
   localparam int IGN_BCK_BIT     = 5;
   localparam int IGN_MCK_BIT     = 4;
   localparam int IGN_HALT_BIT    = 3;
   localparam int IGN_MISS_BIT    = 2;
   localparam int AUTOSET_DIS_BIT = 1;
   localparam int IGN_PLL_BIT     = 0;
   localparam int CLKDET_RSVD_BIT = 7;

   // reset values
   localparam logic [OFS_W-1:0]  OFS_DIV_RST = 7'h04;
   localparam logic [BCK_W-1:0]  BCK_DIV_RST = 7'h00;
   localparam logic [FRM_W-1:0]  FRM_DIV_RST = 8'h00;
   localparam logic [RATE_W-1:0] RATE_RST    = 3'h4;
   localparam logic [7:0]        CLKDET_RST  = 8'h00;

   // rate band codes; others are reserved
   localparam logic [RATE_W-1:0] RATE_48K = 3'h3;
   localparam logic [RATE_W-1:0] RATE_96K = 3'h4;
   localparam logic [RATE_W-1:0] RATE_32K = 3'h7;

   // values the autoset engine proposes
   typedef struct packed {
      logic [OFS_W-1:0]  ofs_div;
      logic [BCK_W-1:0]  bck_div;
      logic [FRM_W-1:0]  frm_div;
      logic [RATE_W-1:0] rate_band;
   } acd_auto_s;

   // raw clock detector reports, active high
   typedef struct packed {
      logic rate_fault;
      logic bitclk_fault;
      logic masterclk_fault;
      logic clock_halt;
      logic clock_missing;
      logic pll_unlocked;
   } acd_fault_s;

endpackage : acd_pkg

/* File: acd_clk_div.sv */
// acd_clk_div: divide-by-(ratio+1) counter advanced by an enable pulse.
// assumes ratio may change at any time; it is only taken at a wrap or while held in reset or idle.
`timescale 1ns/1ns
module acd_clk_div #(
   parameter int W = 7
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         run,
   input  wire logic         adv,
   input  wire logic [W-1:0] ratio,
   output logic              tick,
   output logic              clk_out
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] ratio_q;

   // reload at wrap
   // while running, the new ratio is latched only at the period end, so no runt cycle
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         cnt_q   <= '0;
         ratio_q <= ratio;
      end else if (adv) begin
         if (cnt_q == ratio_q) begin
            cnt_q   <= '0;
            ratio_q <= ratio;
         end else begin
            cnt_q <= cnt_q + W'(1);
         end
      end
   end

   // tick at the last count of each period
   assign tick = run && adv && (cnt_q == ratio_q);

   // high for the first half; divide by 1 stays high (limitation)
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         clk_out <= 1'b0;
      end else begin
         clk_out <= (cnt_q <= (ratio_q >> 1));
      end
   end
endmodule : acd_clk_div

/* File: acd_top.sv */
// acd_top: clock divider configuration registers, master-mode clock
// generators, clock error qualification and the sticky interrupt flag.
// assumes all inputs come from logic on clk; master clock is clk itself.
`timescale 1ns/1ns

// Functional notes
// - offset calibrator clock divides by field plus one
// - master bit clock divides master clock by field+1
// - master frame clock divides bit clock by field+1
// - interpolation 8x at 0, 16x at 1
// - rate band codes 011, 100, 111 only
// - autoset overrides programmed rate band
// - sticky bit 0 mirrors interrupt pin
// - reading sticky register clears flag and pin
// - mask selects which events raise interrupt
// - ignore bit suppresses rate fault clock error
// - autoset disable selects manual divider values
// - ignore bit suppresses pll lock clock error
// - ignore bit blocks dac powerdown on missing clocks
module acd_top (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   // register port
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   input  wire logic [7:0]                reg_addr,
   input  wire logic [7:0]                reg_wdata,
   output logic      [7:0]                reg_rdata,
   output logic                           reg_rvalid,
   // clocking context
   input  wire logic                      master_mode,
   input  wire acd_pkg::acd_auto_s        auto_cfg,
   input  wire acd_pkg::acd_fault_s       faults,
   input  wire logic [acd_pkg::EVT_W-1:0] irq_events,
   input  wire logic [acd_pkg::EVT_W-1:0] irq_mask,
   // generated clocks and status
   output logic                           ofs_cal_tick,
   output logic                           bitclk_out,
   output logic                           frameclk_out,
   output logic                           interp_16x,
   output logic [acd_pkg::RATE_W-1:0]     rate_band_eff,
   output logic                           clock_error,
   output logic                           dac_powerdown,
   output logic                           irq_pin
);
   logic [acd_pkg::OFS_W-1:0]  offset_cal_div_q;
   logic [acd_pkg::BCK_W-1:0]  master_bitclk_div_q;
   logic [acd_pkg::FRM_W-1:0]  master_frameclk_div_q;
   logic                       interp_rate_sel_q;
   logic [acd_pkg::RATE_W-1:0] rate_band_sel_q;
   logic [7:0]                 clkdet_q;
   logic                       sticky_q;

   logic                       autoset_on;
   logic [acd_pkg::OFS_W-1:0]  ofs_ratio;
   logic [acd_pkg::BCK_W-1:0]  bck_ratio;
   logic [acd_pkg::FRM_W-1:0]  frm_ratio;
   logic                       ofs_tick;
   logic                       ofs_lvl;
   logic                       bck_tick;
   logic                       bck_lvl;
   logic                       frm_lvl;
   logic                       err_d;
   logic                       irq_set;
   logic                       sticky_rd;
   logic                       rate_ok;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         offset_cal_div_q <= acd_pkg::OFS_DIV_RST;
      end else if (reg_wr && reg_addr == acd_pkg::OFS_DIV_ADDR) begin
         offset_cal_div_q <= reg_wdata[acd_pkg::OFS_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         master_bitclk_div_q <= acd_pkg::BCK_DIV_RST;
      end else if (reg_wr && reg_addr == acd_pkg::BCK_DIV_ADDR) begin
         master_bitclk_div_q <= reg_wdata[acd_pkg::BCK_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         master_frameclk_div_q <= acd_pkg::FRM_DIV_RST;
      end else if (reg_wr && reg_addr == acd_pkg::FRM_DIV_ADDR) begin
         master_frameclk_div_q <= reg_wdata[acd_pkg::FRM_W-1:0];
      end
   end

   // interpolation select and rate band field
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         interp_rate_sel_q <= 1'b0;
         rate_band_sel_q   <= acd_pkg::RATE_RST;
      end else if (reg_wr && reg_addr == acd_pkg::INTERP_ADDR) begin
         interp_rate_sel_q <= reg_wdata[acd_pkg::INTERP_BIT];
         rate_band_sel_q   <= reg_wdata[acd_pkg::RATE_LSB +: acd_pkg::RATE_W];
      end
   end

   // clock detector ignore bits and autoset disable, all plain r/w
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clkdet_q <= acd_pkg::CLKDET_RST;
      end else if (reg_wr && reg_addr == acd_pkg::CLKDET_ADDR) begin
         clkdet_q <= reg_wdata;
      end
   end

   // manual values only with autoset disabled
   assign autoset_on = !clkdet_q[acd_pkg::AUTOSET_DIS_BIT];
   assign ofs_ratio  = autoset_on ? auto_cfg.ofs_div : offset_cal_div_q;
   assign bck_ratio  = autoset_on ? auto_cfg.bck_div : master_bitclk_div_q;
   assign frm_ratio  = autoset_on ? auto_cfg.frm_div : master_frameclk_div_q;

   // offset calibrator divider, always running off the source clock
   acd_clk_div #(.W(acd_pkg::OFS_W)) u_ofs_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (1'b1),
      .adv     (1'b1),
      .ratio   (ofs_ratio),
      .tick    (ofs_tick),
      .clk_out (ofs_lvl)
   );

   // bit clock divider, held idle outside master mode
   acd_clk_div #(.W(acd_pkg::BCK_W)) u_bck_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (master_mode),
      .adv     (1'b1),
      .ratio   (bck_ratio),
      .tick    (bck_tick),
      .clk_out (bck_lvl)
   );

   // frame clock counts whole bit clock periods
   acd_clk_div #(.W(acd_pkg::FRM_W)) u_frm_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (master_mode),
      .adv     (bck_tick),
      .ratio   (frm_ratio),
      .tick    (),
      .clk_out (frm_lvl)
   );

   // retimed clock outputs
   // divider levels are already flops; one more stage keeps outputs aligned
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ofs_cal_tick <= 1'b0;
         bitclk_out   <= 1'b0;
         frameclk_out <= 1'b0;
      end else begin
         ofs_cal_tick <= ofs_tick;
         bitclk_out   <= bck_lvl;
         frameclk_out <= frm_lvl;
      end
   end

   // only documented codes count as valid
   assign rate_ok = (rate_band_sel_q == acd_pkg::RATE_48K) ||
                    (rate_band_sel_q == acd_pkg::RATE_96K) ||
                    (rate_band_sel_q == acd_pkg::RATE_32K);

   // autoset picks the rate band itself
   // a reserved manual code falls back to the reset band rather than pass
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rate_band_eff <= acd_pkg::RATE_RST;
         interp_16x    <= 1'b0;
      end else begin
         interp_16x <= interp_rate_sel_q;
         if (autoset_on) begin
            rate_band_eff <= auto_cfg.rate_band;
         end else if (rate_ok) begin
            rate_band_eff <= rate_band_sel_q;
         end else begin
            rate_band_eff <= acd_pkg::RATE_RST;
         end
      end
   end

   // clock error qualification by ignore bits
   always_comb begin
      err_d = 1'b0;
      if (faults.rate_fault && !clkdet_q[acd_pkg::IGN_RATE_BIT]) begin
         err_d = 1'b1;
      end
      if (faults.bitclk_fault && !clkdet_q[acd_pkg::IGN_BCK_BIT]) begin
         err_d = 1'b1;
      end
      if (faults.masterclk_fault && !clkdet_q[acd_pkg::IGN_MCK_BIT]) begin
         err_d = 1'b1;
      end
      if (faults.clock_halt && !clkdet_q[acd_pkg::IGN_HALT_BIT]) begin
         err_d = 1'b1;
      end
      if (faults.pll_unlocked && !clkdet_q[acd_pkg::IGN_PLL_BIT]) begin
         err_d = 1'b1;
      end
   end

   // missing clocks power the dac down unless ignored
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clock_error   <= 1'b0;
         dac_powerdown <= 1'b0;
      end else begin
         clock_error   <= err_d;
         dac_powerdown <= faults.clock_missing && !clkdet_q[acd_pkg::IGN_MISS_BIT];
      end
   end

   assign irq_set   = |(irq_events & irq_mask);
   assign sticky_rd = reg_rd && (reg_addr == acd_pkg::STICKY_ADDR);

   // sticky flag, cleared by read
   // a new event in the read cycle wins so it is never lost
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sticky_q <= 1'b0;
      end else if (irq_set) begin
         sticky_q <= 1'b1;
      end else if (sticky_rd) begin
         sticky_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_pin <= 1'b0;
      end else if (irq_set) begin
         irq_pin <= 1'b1;
      end else if (sticky_rd) begin
         irq_pin <= 1'b0;
      end
   end

   // read mux, one cycle latency; unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            unique case (reg_addr)
               acd_pkg::OFS_DIV_ADDR: reg_rdata <= {1'b0, offset_cal_div_q};
               acd_pkg::BCK_DIV_ADDR: reg_rdata <= {1'b0, master_bitclk_div_q};
               acd_pkg::FRM_DIV_ADDR: reg_rdata <= master_frameclk_div_q;
               acd_pkg::INTERP_ADDR:  reg_rdata <= {3'h0, interp_rate_sel_q,
                                                    1'b0, rate_band_sel_q};
               acd_pkg::STICKY_ADDR:  reg_rdata <= {7'h00, sticky_q};
               acd_pkg::CLKDET_ADDR:  reg_rdata <= clkdet_q;
               default:               reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule : acd_top

/* File: acd_top_asserts.sv */
// acd_top_asserts: port checks for acd_top, bound into every instance.
// assumes sync active-high reset and one-cycle read answers.
`timescale 1ns/1ns
module acd_top_asserts (
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [7:0]          reg_addr,
   input wire logic [7:0]          reg_wdata,
   input wire logic [7:0]          reg_rdata,
   input wire logic                reg_rvalid,
   input wire logic                master_mode,
   input wire acd_pkg::acd_fault_s faults,
   input wire logic [7:0]          irq_events,
   input wire logic [7:0]          irq_mask,
   input wire logic                bitclk_out,
   input wire logic                frameclk_out,
   input wire logic                clock_error,
   input wire logic                dac_powerdown,
   input wire logic                irq_pin
);
   logic [7:0] det_q;
   logic       err_exp;
   logic       irq_set;
   logic       rd_flag;
   // shadow of the detector control register
   always_ff @(posedge clk) begin
      if (sys_rst)
         det_q <= 8'h00;
      else if (reg_wr && reg_addr == acd_pkg::CLKDET_ADDR)
         det_q <= reg_wdata;
   end
   // faults whose ignore bit is clear; missing clock never counts
   assign err_exp = (faults.pll_unlocked & ~det_q[0]) | (faults.clock_halt & ~det_q[3])
      | (faults.masterclk_fault & ~det_q[4]) | (faults.bitclk_fault & ~det_q[5])
      | (faults.rate_fault & ~det_q[6]);
   assign irq_set = |(irq_events & irq_mask);
   assign rd_flag = reg_rd && reg_addr == acd_pkg::STICKY_ADDR;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_RVALID: assert property (!$past(sys_rst) |-> reg_rvalid == $past(reg_rd))
      else $error("read answer pulse wrong");
   AST_STICKY_RD: assert property (rd_flag |=> reg_rdata == {7'h00, $past(irq_pin)})
      else $error("sticky read value wrong");
   AST_IRQ_SET: assert property (irq_set |=> irq_pin)
      else $error("enabled event did not raise pin");
   AST_IRQ_CAUSE: assert property ($rose(irq_pin) |-> $past(irq_set))
      else $error("pin rose without enabled event");
   AST_IRQ_CLR: assert property (rd_flag && !irq_set |=> !irq_pin)
      else $error("sticky read did not clear pin");
   AST_IRQ_HOLD: assert property (irq_pin && !rd_flag |=> irq_pin)
      else $error("sticky pin dropped without read");
   AST_CLKERR: assert property (!$past(sys_rst) |-> clock_error == $past(err_exp))
      else $error("clock error qualification wrong");
   AST_PWRDN: assert property (!$past(sys_rst) |->
      dac_powerdown == $past(faults.clock_missing & ~det_q[2]))
      else $error("powerdown qualification wrong");
   AST_MM_OFF: assert property (!master_mode [*2] |=> !bitclk_out && !frameclk_out)
      else $error("clocks run outside master mode");
endmodule : acd_top_asserts
bind acd_top acd_top_asserts u_chk (.*);

/* File: acd_serial_sink.sv */
// acd_serial_sink: serial sink timing the generated bit and frame clocks.
// assumes both clocks are sampled on the system clock.
`timescale 1ns/1ns
module acd_serial_sink (
   input  wire logic clk,
   input  wire logic bitclk,
   input  wire logic frameclk,
   output int        bit_period,
   output int        bit_high,
   output int        frame_period
);
   bit bc_q;
   bit fc_q;
   int bcnt;
   int hcnt;
   int fcnt;
   // periods run rise to rise; high time ends at the fall
   always @(posedge clk) begin
      bc_q <= bitclk;
      fc_q <= frameclk;
      bcnt <= (bitclk && !bc_q) ? 1 : bcnt + 1;
      fcnt <= (frameclk && !fc_q) ? 1 : fcnt + 1;
      hcnt <= (bitclk && !bc_q) ? 1 : hcnt + int'(bitclk);
      if (bitclk && !bc_q)
         bit_period <= bcnt;
      if (!bitclk && bc_q)
         bit_high <= hcnt;
      if (frameclk && !fc_q)
         frame_period <= fcnt;
   end
endmodule : acd_serial_sink

/* File: acd_top_tb.sv */
// acd_top_tb: register-level tests of the clock divider slice.
// assumes the sink model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module acd_top_tb;
   logic                clk, sys_rst, reg_wr, reg_rd, master_mode;
   logic [7:0]          reg_addr, reg_wdata, reg_rdata, irq_events, irq_mask;
   logic                reg_rvalid, ofs_cal_tick, bitclk_out, frameclk_out;
   logic                interp_16x, clock_error, dac_powerdown, irq_pin;
   logic [2:0]          rate_band_eff;
   acd_pkg::acd_auto_s  auto_cfg;
   acd_pkg::acd_fault_s faults;
   int                  errors, checked, cyc, bp, bh, fp;
   logic [7:0]          ra [7] = '{8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
   logic [7:0]          rv [7] = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
   logic [7:0]          ro [7] = '{8'h7f, 8'h7f, 8'hff, 8'h17, 8'h00, 8'h00, 8'hff};
   logic [2:0]          rc [4] = '{3'h3, 3'h4, 3'h7, 3'h5};
   logic [2:0]          re [4] = '{3'h3, 3'h4, 3'h7, 3'h4};
   int                  bk [3] = '{1, 3, 6};
   int                  fk [3] = '{1, 3, 2};

   acd_top dut (.*);
   acd_serial_sink u_sink (.clk(clk), .bitclk(bitclk_out), .frameclk(frameclk_out),
      .bit_period(bp), .bit_high(bh), .frame_period(fp));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard, far above the roughly one thousand cycles expected
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end

   task automatic chk_v(string nm, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk_v
   task automatic chk_c(string nm, int exp, int got);
      checked++;
      if (got != exp) begin
         errors++;
         $display("MISMATCH %s exp %0d got %0d", nm, exp, got);
      end
   endtask : chk_c
   task automatic idle(int n);
      repeat (n) @(negedge clk);
   endtask : idle
   // strobes last one cycle; a spare cycle keeps calls apart
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      idle(1);
      reg_wr = 1'b0;
      idle(1);
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      reg_rd = 1'b1;
      reg_addr = a;
      idle(1);
      reg_rd = 1'b0;
      chk_v("rvalid", 8'h01, {7'h00, reg_rvalid});
      chk_v("rdata", e, reg_rdata);
      idle(1);
   endtask : rd
   task automatic clk_chk(int b, int f);
      idle(100);
      chk_c("bit period", b + 1, bp);
      chk_c("bit high", b / 2 + 1, bh);
      chk_c("frame period", (b + 1) * (f + 1), fp);
   endtask : clk_chk
   // old ratio may run up to 128 cycles before the new one is taken
   task automatic ofs_chk(int r);
      int n;
      n = 0;
      idle(140);
      while (ofs_cal_tick !== 1'b1 && n < 300) begin
         idle(1);
         n++;
      end
      n = 0;
      do begin
         idle(1);
         n++;
      end while (ofs_cal_tick !== 1'b1 && n < 300);
      chk_c("ofs period", r + 1, n);
   endtask : ofs_chk
   task automatic finish_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   initial begin
      {sys_rst, reg_wr, reg_rd, master_mode} = 4'h8;
      {reg_addr, reg_wdata, irq_events, irq_mask} = 32'h0;
      auto_cfg = {7'h03, 7'h02, 8'h02, 3'h7};
      faults = 6'h00;
      // two rising edges in reset, free of the time-zero clock race
      repeat (2) @(posedge clk);
      idle(1);
      sys_rst = 1'b0;
      // reset values, then stored bits of an all-ones write
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      for (int i = 0; i < 7; i++) begin
         wr(ra[i], 8'hff);
         rd(ra[i], ro[i]);
      end
      // every band code plus a reserved one, interpolation toggled
      for (int k = 0; k < 4; k++) begin
         wr(8'h22, {3'h0, k[0], 1'b0, rc[k]});
         idle(2);
         chk_v("band", {5'h00, re[k]}, {5'h00, rate_band_eff});
         chk_v("interp", {7'h00, k[0]}, {7'h00, interp_16x});
      end
      // small ratios while idle; the idle dividers latch them at once,
      // a running one would keep 0x7f/0xff for hundreds of cycles
      wr(8'h20, 8'h01);
      wr(8'h21, 8'h01);
      master_mode = 1'b1;
      for (int k = 0; k < 3; k++) begin
         wr(8'h20, 8'(bk[k]));
         wr(8'h21, 8'(fk[k]));
         clk_chk(bk[k], fk[k]);
      end
      wr(8'h1f, 8'h00);
      ofs_chk(0);
      wr(8'h1f, 8'h09);
      ofs_chk(9);
      // autoset takes the proposed values over the manual ones
      wr(8'h25, 8'h00);
      clk_chk(2, 2);
      chk_v("auto band", 8'h07, {5'h00, rate_band_eff});
      ofs_chk(3);
      wr(8'h25, 8'h02);
      clk_chk(6, 2);
      chk_v("man band", 8'h04, {5'h00, rate_band_eff});
      // each fault regarded, then each ignored
      for (int k = 0; k < 12; k++) begin
         wr(8'h25, k < 6 ? 8'h02 : 8'h7f);
         faults = 6'(1 << (k % 6));
         idle(3);
         chk_v("clkerr", {7'h00, k < 6 && k != 1}, {7'h00, clock_error});
         chk_v("pwrdn", {7'h00, k == 1}, {7'h00, dac_powerdown});
      end
      faults = 6'h00;
      irq_events = 8'h81;
      irq_mask = 8'h7e;
      idle(3);
      chk_v("irq masked", 8'h00, {7'h00, irq_pin});
      irq_mask = 8'h80;
      idle(1);
      irq_events = 8'h00;
      idle(3);
      chk_v("irq held", 8'h01, {7'h00, irq_pin});
      rd(8'h23, 8'h01);
      chk_v("irq cleared", 8'h00, {7'h00, irq_pin});
      rd(8'h23, 8'h00);
      master_mode = 1'b0;
      idle(4);
      chk_v("bitclk off", 8'h00, {7'h00, bitclk_out});
      finish_test();
   end
endmodule : acd_top_tb
